// [common/adc_cfg_pkg.sv]
package adc_cfg_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int DLY_W = 5;
  localparam int OVL_CNT_W = 7;
  localparam int NUM_CH = 4;
  localparam int CORE_W = 2;

  localparam logic [ADDR_W-1:0] TRIM_A_ADDR = 16'h007E;
  localparam logic [ADDR_W-1:0] TRIM_B_ADDR = 16'h007F;
  localparam logic [ADDR_W-1:0] TRIM_C_ADDR = 16'h0080;
  localparam logic [ADDR_W-1:0] TRIM_D_ADDR = 16'h0081;
  localparam logic [ADDR_W-1:0] OVERLAP_DLY_ADDR = 16'h009A;
  localparam logic [ADDR_W-1:0] SELECT_DLY_ADDR = 16'h009B;
  localparam logic [ADDR_W-1:0] DITHER_CTRL_ADDR = 16'h009D;

  localparam logic [DATA_W-1:0] TRIM_RESET = 8'h00;
  localparam logic [DLY_W-1:0] OVERLAP_DLY_RESET = 5'h08;
  localparam logic [DLY_W-1:0] SELECT_DLY_RESET = 5'h07;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  localparam int DLY_LSB = 0;
  localparam int DITHER_EN_BIT = 0;
  localparam int DITHER_AMP_BIT = 1;
  localparam int DITHER_ERR_BIT = 2;

  // Overlap length is OVERLAP_BASE + 2 * delay converter cycles
  localparam logic [OVL_CNT_W-1:0] OVERLAP_BASE = 7'h04;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } regReq_t;

  typedef struct packed {
    logic roundingErrorSelect;
    logic ditherAmplitudeSelect;
    logic ditherEnable;
  } ditherCtrl_t;

  typedef logic [NUM_CH-1:0][DATA_W-1:0] trimBank_t;

  typedef struct packed {
    logic start;
    logic [CORE_W-1:0] target;
  } swapReq_t;

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_SWAP} seqState_t;

endpackage : adc_cfg_pkg

// [design/swap_sequencer.sv]
`timescale 1ns/10ps
module swap_sequencer
  import adc_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input swapReq_t swapReq,
  input wire logic [DLY_W-1:0] overlapDelay,
  input wire logic [DLY_W-1:0] selectDelay,
  output logic overlapActive,
  output logic [CORE_W-1:0] steeringSelect,
  output logic swapBusy
);

  typedef struct packed {
    seqState_t st;
    logic [OVL_CNT_W-1:0] ovCnt;
    logic [OVL_CNT_W-1:0] ovLen;
    logic [DLY_W-1:0] selCnt;
    logic [DLY_W-1:0] selDly;
    logic selDone;
    logic overlap;
    logic [CORE_W-1:0] target;
    logic [CORE_W-1:0] muxSel;
  } seqRegs_t;

  seqRegs_t q, d;

  always_comb begin
    d = q;
    case (q.st)
      SEQ_IDLE: begin
        if (swapReq.start) begin
          // Delays captured at swap start so a late write cannot tear a swap
          d.st = SEQ_SWAP;
          d.ovCnt = '0; // R12
          d.selCnt = '0; // R12
          d.ovLen = OVERLAP_BASE + {1'b0, overlapDelay, 1'b0}; // R3
          d.selDly = selectDelay;
          d.selDone = 1'b0;
          d.overlap = 1'b1; // R3
          d.target = swapReq.target;
        end
      end
      SEQ_SWAP: begin
        if (q.overlap) begin
          d.ovCnt = q.ovCnt + 7'h01; // R12
          if (q.ovCnt == q.ovLen - 7'h01) begin
            d.overlap = 1'b0; // R3
          end
        end
        if (!q.selDone) begin
          if (q.selCnt == q.selDly) begin
            d.muxSel = q.target; // R6
            d.selDone = 1'b1;
          end else begin
            d.selCnt = q.selCnt + 5'h01; // R12
          end
        end
        if (!d.overlap && d.selDone) begin
          d.st = SEQ_IDLE;
        end
      end
      default: begin
        d.st = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{st: SEQ_IDLE, default: '0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign overlapActive = q.overlap;
  assign steeringSelect = q.muxSel;
  assign swapBusy = (q.st == SEQ_SWAP);

  sequence startSeq;
    ce && !swapBusy && swapReq.start;
  endsequence

  sequence dualSampleMin;
    overlapActive [*4];
  endsequence

  AST_OVERLAP_MIN: assert property (@(posedge clk) disable iff (!rst_b) // R3
    startSeq |=> dualSampleMin)
    else $error("overlap shorter than four cycles");

  AST_OVERLAP_LEN: assert property (@(posedge clk) disable iff (!rst_b) // R3
    ($fell(overlapActive) && swapBusy) |-> (q.ovCnt == q.ovLen))
    else $error("overlap length not four plus twice delay");

  AST_COUNT_CLEAR: assert property (@(posedge clk) disable iff (!rst_b) // R12
    startSeq |=> (q.ovCnt == '0 && q.selCnt == '0))
    else $error("swap counters not cleared at start");

  AST_MUX_DELAY: assert property (@(posedge clk) disable iff (!rst_b) // R6
    (ce && swapBusy && !q.selDone && q.selCnt == q.selDly) |=> (steeringSelect == q.target))
    else $error("steering select not switched after delay");

  AST_MUX_ONLY_SWAP: assert property (@(posedge clk) disable iff (!rst_b) // R6
    !swapBusy |=> $stable(steeringSelect))
    else $error("steering select moved outside a swap");

endmodule : swap_sequencer

// [design/adc_trim_swap_dither_regs.sv]
`timescale 1ns/10ps
// Functional notes
// R1: The four channel termination trims load the fused values after reset and stay readable and writable.
// R2: The host writes the overlap delay only while calibration is disabled.
// R3: During a core swap both cores sample the same input for four plus twice the overlap delay cycles.
// R4: The overlap delay is five bits, takes 0 to 31 and resets to eight.
// R5: At a reduced converter clock the host may choose an overlap delay of seven.
// R6: The select delay is added to the steering select and only acts during core swaps.
// R7: The select delay is five bits, takes 0 to 31 and resets to seven.
// R8: The host writes reserved bits as zero.
// R9: Dither control bit 0 enables core dither.
// R10: Dither control bit 1 picks small (0) or large (1) dither amplitude.
// R11: Dither control bit 2 picks whether rounding error hits noise ratio (0) or offset and spurs (1).
// R12: Swap counters clear at the start of every swap and count converter cycles.
module adc_trim_swap_dither_regs
  import adc_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input regReq_t regReq,
  input trimBank_t fuseTrim,
  input swapReq_t swapReq,
  output logic [DATA_W-1:0] regRdata,
  output trimBank_t termTrim,
  output logic [DLY_W-1:0] overlapDelay,
  output logic [DLY_W-1:0] selectDelay,
  output ditherCtrl_t ditherCtrl,
  output logic overlapActive,
  output logic [CORE_W-1:0] steeringSelect,
  output logic swapBusy,
  output logic fuseLoaded
);

  typedef struct packed {
    logic loaded;
    trimBank_t trim;
    logic [DLY_W-1:0] ovl;
    logic [DLY_W-1:0] sel;
    ditherCtrl_t dith;
    logic [DATA_W-1:0] rdata;
  } regState_t;

  localparam logic [ADDR_W-1:0] TRIM_BASE [NUM_CH] = '{TRIM_A_ADDR, TRIM_B_ADDR, TRIM_C_ADDR, TRIM_D_ADDR};

  regState_t q, d;
  logic [NUM_CH-1:0] trimHit;
  swapReq_t seqReq;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : gTrimDecode
      assign trimHit[ch] = (regReq.addr == TRIM_BASE[ch]);

      // A trim moves only on its own write, so a decode slip cannot hit a neighbour
      AST_TRIM_KEEP: assert property (@(posedge clk) disable iff (!rst_b) // R1
        (fuseLoaded && !(ce && regReq.wr && trimHit[ch])) |=> $stable(termTrim[ch]))
        else $error("trim changed without a write");
    end
  endgenerate

  always_comb begin
    d = q;
    if (!q.loaded) begin
      // Fuse pins are only sampled after reset release, never under reset
      d.trim = fuseTrim; // R1
      d.loaded = 1'b1;
    end else begin
      if (regReq.wr) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (trimHit[i]) begin
            d.trim[i] = regReq.wdata; // R1
          end
        end
        // Reserved upper bits are dropped; the host keeps them zero
        if (regReq.addr == OVERLAP_DLY_ADDR) begin
          d.ovl = regReq.wdata[DLY_LSB +: DLY_W]; // R4
        end
        if (regReq.addr == SELECT_DLY_ADDR) begin
          d.sel = regReq.wdata[DLY_LSB +: DLY_W]; // R7
        end
        if (regReq.addr == DITHER_CTRL_ADDR) begin
          d.dith.ditherEnable = regReq.wdata[DITHER_EN_BIT]; // R9
          d.dith.ditherAmplitudeSelect = regReq.wdata[DITHER_AMP_BIT]; // R10
          d.dith.roundingErrorSelect = regReq.wdata[DITHER_ERR_BIT]; // R11
        end
      end
    end
    if (regReq.rd) begin
      d.rdata = UNMAPPED_READ;
      for (int i = 0; i < NUM_CH; i++) begin
        if (trimHit[i]) begin
          d.rdata = q.trim[i]; // R1
        end
      end
      if (regReq.addr == OVERLAP_DLY_ADDR) begin
        d.rdata = {3'h0, q.ovl};
      end
      if (regReq.addr == SELECT_DLY_ADDR) begin
        d.rdata = {3'h0, q.sel};
      end
      if (regReq.addr == DITHER_CTRL_ADDR) begin
        d.rdata = {5'h00, q.dith};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{loaded: 1'b0, trim: {NUM_CH{TRIM_RESET}}, ovl: OVERLAP_DLY_RESET, // R4
             sel: SELECT_DLY_RESET, dith: '0, rdata: '0}; // R7
    end else if (ce) begin
      q <= d;
    end
  end

  assign regRdata = q.rdata;
  assign termTrim = q.trim;
  assign overlapDelay = q.ovl;
  assign selectDelay = q.sel;
  assign ditherCtrl = q.dith;
  assign fuseLoaded = q.loaded;

  // Swap requests are dropped until the fuse load so the trims are settled first
  assign seqReq = '{start: swapReq.start & q.loaded, target: swapReq.target};

  swap_sequencer uSeq (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .swapReq(seqReq),
    .overlapDelay(q.ovl),
    .selectDelay(q.sel),
    .overlapActive(overlapActive),
    .steeringSelect(steeringSelect),
    .swapBusy(swapBusy)
  );

  sequence writeSeq(logic [ADDR_W-1:0] a);
    ce && fuseLoaded && regReq.wr && regReq.addr == a;
  endsequence

  sequence readSeq(logic [ADDR_W-1:0] a);
    ce && regReq.rd && regReq.addr == a;
  endsequence

  AST_FUSE_LOAD: assert property (@(posedge clk) disable iff (!rst_b) // R1
    (ce && !fuseLoaded) |=> (fuseLoaded && termTrim == $past(fuseTrim)))
    else $error("trims did not take fused values");

  AST_TRIM_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // R1
    writeSeq(TRIM_C_ADDR) |=> (termTrim[2] == $past(regReq.wdata)))
    else $error("trim write lost");

  AST_DELAY_DEFAULTS: assert property (@(posedge clk) disable iff (!rst_b) // R4
    !fuseLoaded |-> (overlapDelay == OVERLAP_DLY_RESET && selectDelay == SELECT_DLY_RESET))
    else $error("delay reset values wrong");

  AST_OVL_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // R4
    writeSeq(OVERLAP_DLY_ADDR) |=> (overlapDelay == $past(regReq.wdata[DLY_W-1:0])))
    else $error("overlap delay write lost");

  AST_SEL_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // R7
    writeSeq(SELECT_DLY_ADDR) |=> (selectDelay == $past(regReq.wdata[DLY_W-1:0])))
    else $error("select delay write lost");

  AST_DITHER_EN: assert property (@(posedge clk) disable iff (!rst_b) // R9
    writeSeq(DITHER_CTRL_ADDR) |=> (ditherCtrl.ditherEnable == $past(regReq.wdata[DITHER_EN_BIT])))
    else $error("dither enable not bit zero");

  AST_DITHER_AMP: assert property (@(posedge clk) disable iff (!rst_b) // R10
    writeSeq(DITHER_CTRL_ADDR) |=> (ditherCtrl.ditherAmplitudeSelect == $past(regReq.wdata[DITHER_AMP_BIT])))
    else $error("dither amplitude not bit one");

  AST_DITHER_ERR: assert property (@(posedge clk) disable iff (!rst_b) // R11
    writeSeq(DITHER_CTRL_ADDR) |=> (ditherCtrl.roundingErrorSelect == $past(regReq.wdata[DITHER_ERR_BIT])))
    else $error("rounding error select not bit two");

  AST_OVL_READ: assert property (@(posedge clk) disable iff (!rst_b) // R4
    (ce && regReq.rd && regReq.addr == OVERLAP_DLY_ADDR) |=> (regRdata == {3'h0, $past(overlapDelay)}))
    else $error("overlap delay readback wrong");

  AST_SEL_READ: assert property (@(posedge clk) disable iff (!rst_b) // R7
    readSeq(SELECT_DLY_ADDR) |=> (regRdata == {3'h0, $past(selectDelay)}))
    else $error("select delay readback wrong");

  AST_DITHER_READ: assert property (@(posedge clk) disable iff (!rst_b) // R9
    readSeq(DITHER_CTRL_ADDR) |=> (regRdata == {5'h00, $past(ditherCtrl)}))
    else $error("dither control readback wrong");

  AST_TRIM_READ: assert property (@(posedge clk) disable iff (!rst_b) // R1
    readSeq(TRIM_A_ADDR) |=> (regRdata == $past(termTrim[0])))
    else $error("trim readback wrong");

  // Holes in the map read as zero so software sees no stale byte
  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_b) // R1
    (ce && regReq.rd && !(|trimHit) && regReq.addr != OVERLAP_DLY_ADDR && regReq.addr != SELECT_DLY_ADDR
      && regReq.addr != DITHER_CTRL_ADDR) |=> (regRdata == UNMAPPED_READ))
    else $error("unmapped read not zero");

  AST_OVL_KEEP: assert property (@(posedge clk) disable iff (!rst_b) // R4
    (fuseLoaded && !(ce && regReq.wr && regReq.addr == OVERLAP_DLY_ADDR)) |=> $stable(overlapDelay))
    else $error("overlap delay changed without a write");

  AST_SEL_KEEP: assert property (@(posedge clk) disable iff (!rst_b) // R7
    (fuseLoaded && !(ce && regReq.wr && regReq.addr == SELECT_DLY_ADDR)) |=> $stable(selectDelay))
    else $error("select delay changed without a write");

  AST_DITHER_KEEP: assert property (@(posedge clk) disable iff (!rst_b) // R9
    (fuseLoaded && !(ce && regReq.wr && regReq.addr == DITHER_CTRL_ADDR)) |=> $stable(ditherCtrl))
    else $error("dither control changed without a write");

  // Low clock enable must hold every register, the read latch included
  AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_b) // R1
    !ce |=> ($stable(termTrim) && $stable(overlapDelay) && $stable(selectDelay) && $stable(ditherCtrl)
      && $stable(regRdata) && $stable(fuseLoaded)))
    else $error("state moved while clock enable low");

  AST_SWAP_GATED: assert property (@(posedge clk) disable iff (!rst_b) // R12
    !fuseLoaded |-> !swapBusy)
    else $error("swap running before fuse load");

  // Writes in the fuse-load cycle are refused, so the defaults survive it
  AST_EARLY_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // R4
    (ce && !fuseLoaded) |=> (overlapDelay == OVERLAP_DLY_RESET && selectDelay == SELECT_DLY_RESET))
    else $error("write taken before fuse load");

endmodule : adc_trim_swap_dither_regs

// [test/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import adc_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b0;
  regReq_t regReq = '0;
  trimBank_t fuseTrim = '0;
  swapReq_t swapReq = '0;
  logic [DATA_W-1:0] regRdata;
  trimBank_t termTrim;
  logic [DLY_W-1:0] overlapDelay;
  logic [DLY_W-1:0] selectDelay;
  ditherCtrl_t ditherCtrl;
  logic overlapActive;
  logic [CORE_W-1:0] steeringSelect;
  logic swapBusy;
  logic fuseLoaded;
  int failures = 0;
  int compares = 0;
  logic [ADDR_W-1:0] trimAddr [NUM_CH] = '{TRIM_A_ADDR, TRIM_B_ADDR, TRIM_C_ADDR, TRIM_D_ADDR};
  logic [CORE_W-1:0] steerExp = '0;

  always #10 clk = ~clk;

  adc_trim_swap_dither_regs u_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .regReq(regReq), .fuseTrim(fuseTrim), .swapReq(swapReq),
    .regRdata(regRdata), .termTrim(termTrim), .overlapDelay(overlapDelay), .selectDelay(selectDelay),
    .ditherCtrl(ditherCtrl), .overlapActive(overlapActive), .steeringSelect(steeringSelect),
    .swapBusy(swapBusy), .fuseLoaded(fuseLoaded)
  );

  function automatic int ovlLen(input logic [DLY_W-1:0] d);
    return 4 + 2 * d;
  endfunction : ovlLen

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test;
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // A leading idle cycle keeps back-to-back calls from touching a strobe twice at one edge
  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq.wr = 1'b1;
    regReq.addr = a;
    regReq.wdata = d;
    @(negedge clk);
    regReq.wr = 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(negedge clk);
    regReq.rd = 1'b1;
    regReq.addr = a;
    @(negedge clk);
    regReq.rd = 1'b0;
    check("regRdata", exp, regRdata);
  endtask : regRead

  task automatic runSwap(input logic [DLY_W-1:0] ovl, input logic [DLY_W-1:0] sel);
    logic [CORE_W-1:0] old;
    logic [CORE_W-1:0] tgt;
    int len;
    int last;
    // Delays written only between swaps, reserved bits kept zero
    regWrite(OVERLAP_DLY_ADDR, {3'h0, ovl});
    regWrite(SELECT_DLY_ADDR, {3'h0, sel});
    old = steerExp;
    tgt = old + 2'($urandom_range(1, 3));
    len = ovlLen(ovl);
    last = (len > sel + 2) ? len : sel + 2;
    @(negedge clk);
    swapReq.start = 1'b1;
    swapReq.target = tgt;
    for (int k = 1; k <= last + 1; k++) begin
      @(negedge clk);
      // Second start while busy must be dropped
      swapReq.start = (k == 2);
      swapReq.target = ~tgt;
      check("overlapActive", {7'h0, k <= len}, {7'h0, overlapActive});
      check("steeringSelect", {6'h0, (k >= sel + 2) ? tgt : old}, {6'h0, steeringSelect});
      check("swapBusy", {7'h0, k <= len || k <= sel + 1}, {7'h0, swapBusy});
    end
    check("swapBusy", 8'h00, {7'h0, swapBusy});
    steerExp = tgt;
  endtask : runSwap

  initial begin
    #200000;
    failures++;
    finish_test;
  end

  initial begin
    logic [7:0] w;
    logic [7:0] trimExp [NUM_CH];
    void'($urandom(32'hA32B3EFF));
    fuseTrim = trimBank_t'($urandom);
    repeat (10) @(negedge clk);
    check("overlapDelay", 8'h08, {3'h0, overlapDelay});
    check("selectDelay", 8'h07, {3'h0, selectDelay});
    check("ditherCtrl", 8'h00, {5'h0, ditherCtrl});
    check("fuseLoaded", 8'h00, {7'h0, fuseLoaded});
    rst_b = 1'b1;
    ce = 1'b1;
    for (int i = 0; i < 10 && fuseLoaded !== 1'b1; i++) @(negedge clk);
    check("fuseLoaded", 8'h01, {7'h0, fuseLoaded});
    for (int i = 0; i < NUM_CH; i++) begin
      check("termTrim", fuseTrim[i], termTrim[i]);
      regRead(trimAddr[i], fuseTrim[i]);
      w = 8'($urandom);
      trimExp[i] = w;
      regWrite(trimAddr[i], w);
      regRead(trimAddr[i], w);
      check("termTrim", w, termTrim[i]);
    end
    // Frozen clock enable must drop the write
    ce = 1'b0;
    regWrite(TRIM_A_ADDR, ~trimExp[0]);
    ce = 1'b1;
    check("termTrim", trimExp[0], termTrim[0]);
    regRead(TRIM_A_ADDR, trimExp[0]);
    regRead(OVERLAP_DLY_ADDR, 8'h08);
    regRead(SELECT_DLY_ADDR, 8'h07);
    // Host keeps the reserved upper bits zero
    regWrite(OVERLAP_DLY_ADDR, 8'h1F);
    check("overlapDelay", 8'h1F, {3'h0, overlapDelay});
    regRead(OVERLAP_DLY_ADDR, 8'h1F);
    regWrite(SELECT_DLY_ADDR, 8'h1F);
    check("selectDelay", 8'h1F, {3'h0, selectDelay});
    regRead(SELECT_DLY_ADDR, 8'h1F);
    for (int b = 0; b < 3; b++) begin
      regWrite(DITHER_CTRL_ADDR, 8'h01 << b);
      check("ditherCtrl", 8'h01 << b, {5'h0, ditherCtrl});
      regRead(DITHER_CTRL_ADDR, 8'h01 << b);
    end
    regRead(16'h009C, UNMAPPED_READ);
    // Mid-run reset must restore defaults and reload fresh fuse values
    fuseTrim = trimBank_t'($urandom);
    rst_b = 1'b0;
    @(negedge clk);
    check("fuseLoaded", 8'h00, {7'h0, fuseLoaded});
    check("ditherCtrl", 8'h00, {5'h0, ditherCtrl});
    check("overlapDelay", 8'h08, {3'h0, overlapDelay});
    check("selectDelay", 8'h07, {3'h0, selectDelay});
    rst_b = 1'b1;
    @(negedge clk);
    check("fuseLoaded", 8'h01, {7'h0, fuseLoaded});
    for (int i = 0; i < NUM_CH; i++) begin
      check("termTrim", fuseTrim[i], termTrim[i]);
    end
    runSwap(5'h00, 5'h00);
    runSwap(5'h1F, 5'h00);
    runSwap(5'h00, 5'h1F);
    runSwap(5'h07, 5'h03);
    for (int i = 0; i < 6; i++) begin
      runSwap(5'($urandom), 5'($urandom));
    end
    finish_test;
  end
endmodule : testbench
